// ### comparator_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// analogue comparator stand-in
// ----------------------------------------
// load_level: 0 none, 1 above low, 2 above mid, 3 above high
// supply_state: 0 normal, 1 under, 2 over, 3 inside the hysteresis band
module comparator_model (
   input wire logic channel_on,
   input wire logic [1:0] load_level,
   input wire logic short_cmd,
   input wire logic [1:0] supply_state,
   output logic cur_above_high,
   output logic cur_above_mid,
   output logic cur_above_low,
   output logic short_detect,
   output logic supply_ov,
   output logic supply_ov_low,
   output logic supply_uv
);
   // no load current flows while the switch is off, so pwm off-times carry no overcurrent
   assign cur_above_low = channel_on && load_level >= 2'h1;
   assign cur_above_mid = channel_on && load_level >= 2'h2;
   assign cur_above_high = channel_on && load_level == 2'h3;
   assign short_detect = short_cmd;
   assign supply_ov = supply_state == 2'h2;
   // the band keeps ov_low low, so release needs a real drop below the hysteresis
   assign supply_ov_low = !supply_state[1];
   assign supply_uv = supply_state == 2'h1;
endmodule

// ### ocp_defs.svh
`ifndef OCP_DEFS_SVH
`define OCP_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_FAULT 5'h00
`define OFS_STATUS 5'h04
`define OFS_GCFG 5'h08
`define OFS_OCCFG 5'h0c
`define OFS_TC_OCH1 5'h10
`define OFS_TC_OCH2 5'h14
`define OFS_TC_OCM1 5'h18
`define OFS_TC_OCM2 5'h1c
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_OC 0
`define BIT_SC 1
`define BIT_OV 0
`define BIT_UV 1
`define BIT_PROF 2
`define BIT_OVDIS 0
`define BIT_PSRC 0
`define BIT_W1SEL 1
`define BIT_W2SEL 2
// ----------------------------------------
// reset values and time base
// ----------------------------------------
`define RST_GCFG 1'h0
`define RST_OCCFG 3'h0
`define RST_TC_OCH1 16'h0010
`define RST_TC_OCH2 16'h0020
`define RST_TC_OCM1 16'h0040
`define RST_TC_OCM2 16'h0080
`define TICK_DIV 125
`endif

// ### ocp_pkg.sv
package ocp_pkg;
   typedef enum logic [1:0]
   {
      win_idle = 2'b00,
      win_first = 2'b01,
      win_second = 2'b10,
      win_motor = 2'b11
   } win_state_type;
endpackage

// ### overcurrent_fault_protection.sv
`timescale 1ns/1ps
`include "ocp_defs.svh"
// Behaviour
// - overcurrent: channel off, flag set, pin low
// - trip on threshold cross or window overrun
// - window active blanks sense, strobe high
// - source bit 0 pin, 1 inverted pin
// - reset takes pin; reported bit combines both
// - profile 0 lighting, 1 motor
// - lighting: three thresholds, two windows
// - lighting restart each turn-on, switch once
// - motor: one window opened above low
// - latch when retry disabled or retries used up
// - switch mode when duty below full
// - count on-time only, switching resets only a clean motor on-period
// - delatch resets counter; lighting retry too
// - motor: clean on-period resets at turn-off
// - short at turn-on: off, pin, flag
// - overvoltage: off until hysteresis clears
// - status read clears cleared overvoltage flag
// - disable bit: warning flag only
// - undervoltage: off, pin low, flag
// - command off: pin releases, flag held
// - command on: needs delatch or reset
// - read or supply loss clears faults
// - overcurrent flag at bit 0
// - short flag at bit 1
// - retry request from latchable flags
module overcurrent_fault_protection #(
   parameter int CNT_W = 16,
   parameter int TICK_DIV = `TICK_DIV
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic on_cmd,
   input wire logic switch_mode,
   input wire logic profile_pin,
   input wire logic cur_above_high,
   input wire logic cur_above_mid,
   input wire logic cur_above_low,
   input wire logic short_detect,
   input wire logic supply_ov,
   input wire logic supply_ov_low,
   input wire logic supply_uv,
   input wire logic supply_por,
   input wire logic delatch,
   input wire logic retry_enable,
   input wire logic retry_exhausted,
   input wire logic retry_turn_on,
   input wire logic overheat_flag,
   output logic channel_on,
   output logic fault_status_n,
   output logic sense_valid_strobe_pin,
   output logic retry_request
);
   import ocp_pkg::*;
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic waitrequest_ff;
   logic [31:0] readdata_ff;
   logic overvoltage_disable_ff;
   logic [2:0] occfg_ff;
   logic [CNT_W-1:0] tc_ff [0:3];
   logic channel_on_ff;
   logic fault_n_ff;
   logic strobe_ff;
   logic retry_ff;
   logic overcurrent_flag_ff;
   logic short_circuit_flag_ff;
   logic overvoltage_flag_ff;
   logic undervoltage_flag_ff;
   logic trip_ff;
   logic lock_ff;
   logic ov_block_ff;
   logic uv_block_ff;
   logic started_ff;
   logic period_oc_ff;
   logic [CNT_W-1:0] dur_ff;
   logic [7:0] div_ff;
   win_state_type win_ff;
   win_state_type nxt_win;
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = read | write;
   wire done = req & ~waitrequest_ff;
   wire wr_go = done & write;
   wire rd_go = done & read;
   wire rd_fault = rd_go & (address == `OFS_FAULT);
   wire rd_status = rd_go & (address == `OFS_STATUS);
   wire load_profile_select = occfg_ff[`BIT_PSRC] ^ profile_pin;
   wire motor = load_profile_select;
   wire [CNT_W-1:0] tc_first = occfg_ff[`BIT_W1SEL] ? tc_ff[1] : tc_ff[0];
   wire [CNT_W-1:0] tc_second = occfg_ff[`BIT_W2SEL] ? tc_ff[3] : tc_ff[2];
   wire [CNT_W-1:0] tc_act = (win_ff == win_first) ? tc_first : tc_second;
   wire tick = (div_ff == 8'(TICK_DIV - 1));
   wire win_on = (win_ff != win_idle);
   wire overrun = win_on & (dur_ff > tc_act);
   wire nxt_on;
   wire oc_det;
   wire turn_on_ev = on_cmd & ~channel_on_ff & nxt_on;
   wire turn_off_ev = channel_on_ff & ~nxt_on;
   wire sc_det = short_detect & channel_on_ff;
   wire fault_det = oc_det | sc_det;
   wire ov_cut = supply_ov & ~overvoltage_disable_ff;

   function automatic logic [31:0] reg_read(input logic [4:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         `OFS_FAULT:
         begin
            v[`BIT_OC] = overcurrent_flag_ff;
            v[`BIT_SC] = short_circuit_flag_ff;
         end
         `OFS_STATUS:
         begin
            v[`BIT_OV] = overvoltage_flag_ff;
            v[`BIT_UV] = undervoltage_flag_ff;
            v[`BIT_PROF] = load_profile_select;
         end
         `OFS_GCFG: v[`BIT_OVDIS] = overvoltage_disable_ff;
         `OFS_OCCFG: v[2:0] = occfg_ff;
         `OFS_TC_OCH1: v[CNT_W-1:0] = tc_ff[0];
         `OFS_TC_OCH2: v[CNT_W-1:0] = tc_ff[1];
         `OFS_TC_OCM1: v[CNT_W-1:0] = tc_ff[2];
         `OFS_TC_OCM2: v[CNT_W-1:0] = tc_ff[3];
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // avalon slave: one wait cycle per access
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         waitrequest_ff <= 1'b1;
         readdata_ff <= 32'h0;
      end
      else
      begin
         waitrequest_ff <= ~(req & waitrequest_ff);
         if (read & waitrequest_ff)
            readdata_ff <= reg_read(address);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         overvoltage_disable_ff <= `RST_GCFG;
         occfg_ff <= `RST_OCCFG;
      end
      else if (wr_go)
      begin
         if (address == `OFS_GCFG)
            overvoltage_disable_ff <= writedata[`BIT_OVDIS];
         if (address == `OFS_OCCFG)
            occfg_ff <= writedata[2:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_tc
         localparam logic [CNT_W-1:0] RV = (gi == 0) ? CNT_W'(`RST_TC_OCH1) :
            (gi == 1) ? CNT_W'(`RST_TC_OCH2) : (gi == 2) ? CNT_W'(`RST_TC_OCM1) : CNT_W'(`RST_TC_OCM2);
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               tc_ff[gi] <= RV;
            else if (wr_go && address == 5'(`OFS_TC_OCH1 + 4 * gi))
               tc_ff[gi] <= writedata[CNT_W-1:0];
         end
      end
   endgenerate

   // ----------------------------------------
   // profile window engine
   // ----------------------------------------
   // lighting restarts at each turn-on unless switching, where only the first one counts
   wire light_start = ~motor & (turn_on_ev | retry_turn_on) & ~(switch_mode & started_ff);
   assign oc_det = channel_on_ff & (overrun | cur_above_high
      | (win_ff == win_second & cur_above_mid)
      | (win_ff == win_idle & ~motor & cur_above_low));

   always_comb
   begin
      nxt_win = win_ff;
      case (win_ff)
         win_idle:
            if (light_start)
               nxt_win = win_first;
            else if (motor & cur_above_low & channel_on_ff)
               nxt_win = win_motor;
         win_first:
            if (dur_ff == tc_first)
               nxt_win = win_second;
         win_second:
            if (dur_ff == tc_second)
               nxt_win = win_idle;
         win_motor:
            if (~cur_above_low)
               nxt_win = win_idle;
         default: nxt_win = win_idle;
      endcase
      if (fault_det | delatch)
         nxt_win = win_idle;
   end

   wire cnt_clr = delatch | (~motor & retry_turn_on)
      | (motor & turn_off_ev & ~period_oc_ff)
      | light_start | (win_ff != nxt_win & win_ff != win_motor & nxt_win != win_motor);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         win_ff <= win_idle;
         dur_ff <= '0;
         div_ff <= 8'h0;
      end
      else
      begin
         win_ff <= nxt_win;
         div_ff <= tick ? 8'h0 : div_ff + 8'h1;
         if (cnt_clr)
            dur_ff <= '0;
         else if (tick & channel_on_ff & win_on & ~&dur_ff)
            dur_ff <= dur_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         started_ff <= 1'b0;
         period_oc_ff <= 1'b0;
      end
      else
      begin
         if (delatch)
            started_ff <= 1'b0;
         else if (turn_on_ev)
            started_ff <= 1'b1;
         if (turn_on_ev)
            period_oc_ff <= 1'b0;
         else if (win_ff == win_motor)
            period_oc_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // fault latching and channel control
   // ----------------------------------------
   assign nxt_on = on_cmd & ~trip_ff & ~fault_det & ~ov_block_ff & ~ov_cut & ~uv_block_ff & ~supply_uv;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         trip_ff <= 1'b0;
         lock_ff <= 1'b0;
         ov_block_ff <= 1'b0;
         uv_block_ff <= 1'b0;
      end
      else
      begin
         if (fault_det)
            trip_ff <= 1'b1;
         else if (delatch | supply_por | (retry_turn_on & ~lock_ff))
            trip_ff <= 1'b0;
         if (fault_det & (~retry_enable | retry_exhausted))
            lock_ff <= 1'b1;
         else if (delatch | supply_por)
            lock_ff <= 1'b0;
         if (ov_cut)
            ov_block_ff <= 1'b1;
         else if (supply_ov_low | overvoltage_disable_ff)
            ov_block_ff <= 1'b0;
         if (supply_uv)
            uv_block_ff <= 1'b1;
         else if (~on_cmd | delatch | supply_por)
            uv_block_ff <= 1'b0;
      end
   end

   // flags: a new event in the clearing cycle keeps the flag set
   wire fault_rc = rd_fault & ~trip_ff & ~fault_det;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         overcurrent_flag_ff <= 1'b0;
         short_circuit_flag_ff <= 1'b0;
         overvoltage_flag_ff <= 1'b0;
         undervoltage_flag_ff <= 1'b0;
      end
      else
      begin
         if (oc_det)
            overcurrent_flag_ff <= 1'b1;
         else if (fault_rc | supply_por)
            overcurrent_flag_ff <= 1'b0;
         if (sc_det)
            short_circuit_flag_ff <= 1'b1;
         else if (fault_rc | supply_por)
            short_circuit_flag_ff <= 1'b0;
         if (supply_ov)
            overvoltage_flag_ff <= 1'b1;
         else if ((rd_status & ~ov_block_ff) | supply_por)
            overvoltage_flag_ff <= 1'b0;
         if (supply_uv)
            undervoltage_flag_ff <= 1'b1;
         else if ((rd_status & ~uv_block_ff) | (channel_on_ff & ~on_cmd) | supply_por)
            undervoltage_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         channel_on_ff <= 1'b0;
         fault_n_ff <= 1'b1;
         strobe_ff <= 1'b0;
         retry_ff <= 1'b0;
      end
      else
      begin
         channel_on_ff <= nxt_on;
         fault_n_ff <= ~(trip_ff | fault_det | ov_cut | ov_block_ff | supply_uv | uv_block_ff);
         strobe_ff <= win_on | nxt_win != win_idle;
         retry_ff <= overcurrent_flag_ff | short_circuit_flag_ff | overheat_flag | undervoltage_flag_ff;
      end
   end

   assign readdata = readdata_ff;
   assign waitrequest = waitrequest_ff;
   assign channel_on = channel_on_ff;
   assign fault_status_n = fault_n_ff;
   assign sense_valid_strobe_pin = strobe_ff;
   assign retry_request = retry_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_oc_off;
      @(posedge clk) disable iff (!rstn) oc_det |=> !channel_on && overcurrent_flag_ff ##1 !fault_status_n;
   endproperty
   a_oc_off: assert property (p_oc_off) else $error("overcurrent did not shut channel");
   property p_blank;
      @(posedge clk) disable iff (!rstn) win_on |=> sense_valid_strobe_pin;
   endproperty
   a_blank: assert property (p_blank) else $error("strobe low during window");
   property p_overrun;
      @(posedge clk) disable iff (!rstn) (channel_on_ff && overrun) |=> !channel_on;
   endproperty
   a_overrun: assert property (p_overrun) else $error("window overrun not tripped");
   property p_sc;
      @(posedge clk) disable iff (!rstn) sc_det |=> short_circuit_flag_ff && !channel_on;
   endproperty
   a_sc: assert property (p_sc) else $error("short not latched");
   property p_ov;
      @(posedge clk) disable iff (!rstn) (supply_ov && !overvoltage_disable_ff) |=> !channel_on ##1 !fault_status_n;
   endproperty
   a_ov: assert property (p_ov) else $error("overvoltage not acted on");
   property p_ovdis;
      @(posedge clk) disable iff (!rstn) supply_ov |=> overvoltage_flag_ff;
   endproperty
   a_ovdis: assert property (p_ovdis) else $error("overvoltage flag missing");
   property p_uv;
      @(posedge clk) disable iff (!rstn) supply_uv |=> undervoltage_flag_ff && !channel_on ##1 !fault_status_n;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage not acted on");
   property p_lock;
      @(posedge clk) disable iff (!rstn) (lock_ff && !delatch && !supply_por) |=> !channel_on;
   endproperty
   a_lock: assert property (p_lock) else $error("latched channel turned on");
   property p_delatch;
      @(posedge clk) disable iff (!rstn) delatch |=> dur_ff == '0;
   endproperty
   a_delatch: assert property (p_delatch) else $error("delatch left counter");
   property p_bus;
      @(posedge clk) disable iff (!rstn) (req && waitrequest) |=> !waitrequest ##1 waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");
   c_light: cover property (@(posedge clk) disable iff (!rstn) win_ff == win_first ##1 win_ff == win_second);
   c_motor: cover property (@(posedge clk) disable iff (!rstn) win_ff == win_motor && overrun);
   c_uv: cover property (@(posedge clk) disable iff (!rstn) supply_uv ##1 !supply_uv && on_cmd);
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "ocp_defs.svh"
module testbench;
   logic clk, rstn, read, write, on_cmd, switch_mode, profile_pin, delatch, supply_por, short_cmd;
   logic retry_enable, retry_exhausted, retry_turn_on, overheat_flag, waitrequest, channel_on;
   logic fault_status_n, strobe, retry_request, c_hi, c_mid, c_lo, c_sc, s_ov, s_ovl, s_uv;
   logic [4:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [1:0] load_level, supply_state;
   int num_errors, check_count, cyc, t, p;
   localparam int DIV = 2;
   logic [4:0] ofs [7] = '{`OFS_GCFG, `OFS_OCCFG, `OFS_TC_OCH1, `OFS_TC_OCH2, `OFS_TC_OCM1, `OFS_TC_OCM2, 5'h01};
   logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h10, 32'h20, 32'h40, 32'h80, 32'h0};
   overcurrent_fault_protection #(.TICK_DIV(DIV)) u_overcurrent_fault_protection (.clk(clk), .rstn(rstn),
      .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .on_cmd(on_cmd), .switch_mode(switch_mode), .profile_pin(profile_pin),
      .cur_above_high(c_hi), .cur_above_mid(c_mid), .cur_above_low(c_lo), .short_detect(c_sc),
      .supply_ov(s_ov), .supply_ov_low(s_ovl), .supply_uv(s_uv), .supply_por(supply_por), .delatch(delatch),
      .retry_enable(retry_enable), .retry_exhausted(retry_exhausted), .retry_turn_on(retry_turn_on),
      .overheat_flag(overheat_flag), .channel_on(channel_on), .fault_status_n(fault_status_n),
      .sense_valid_strobe_pin(strobe), .retry_request(retry_request));
   comparator_model u_comparator_model (.channel_on(channel_on), .load_level(load_level),
      .short_cmd(short_cmd), .supply_state(supply_state), .cur_above_high(c_hi), .cur_above_mid(c_mid),
      .cur_above_low(c_lo), .short_detect(c_sc), .supply_ov(s_ov), .supply_ov_low(s_ovl), .supply_uv(s_uv));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // only the watchdog ends a bus wait, so a slave that never answers still fails the run
   task rw(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'b0)
         @(posedge clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task wait_ch(input logic v);
      cyc = 0;
      while (channel_on !== v && cyc < 400)
      begin
         @(posedge clk);
         cyc++;
      end
   endtask
   task go;
      @(posedge clk);
      on_cmd <= 1'b1;
      wait_ch(1'b1);
   endtask
   task pulse_delatch;
      @(posedge clk);
      delatch <= 1'b1;
      @(posedge clk);
      delatch <= 1'b0;
   endtask
   // faults are latched, so every test after the profile test leaves through a delatch and clearing reads
   task recover;
      @(posedge clk);
      on_cmd <= 1'b0;
      load_level <= 2'h0;
      short_cmd <= 1'b0;
      supply_state <= 2'h0;
      switch_mode <= 1'b0;
      retry_enable <= 1'b0;
      step(3);
      pulse_delatch();
      repeat (2)
      begin
         rw(1'b0, `OFS_FAULT, 32'h0);
         rw(1'b0, `OFS_STATUS, 32'h0);
      end
   endtask
   task done(input string name);
      $display("test %s ended, errors so far %0d", name, num_errors);
   endtask
   task close_out;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      num_errors++;
      close_out();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {rstn, read, write, on_cmd, switch_mode, profile_pin, delatch, supply_por, short_cmd} = '0;
      {retry_enable, retry_exhausted, retry_turn_on, overheat_flag, load_level, supply_state} = '0;
      address = 5'h00;
      writedata = 32'h0;
      void'($urandom(7));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(32'({channel_on, fault_status_n, strobe, retry_request}), 32'h4);
      rw(1'b1, 5'h01, 32'hffff_ffff);
      for (int i = 0; i < 7; i++)
      begin
         rw(1'b0, ofs[i], 32'h0);
         chk(rd, rst_val[i]);
      end
      done("reset");
      for (int i = 0; i < 4; i++)
      begin
         profile_pin <= i[0];
         rw(1'b1, `OFS_OCCFG, 32'(i[1]));
         rw(1'b0, `OFS_STATUS, 32'h0);
         chk(32'(rd[`BIT_PROF]), 32'(i[0] ^ i[1]));
      end
      profile_pin <= 1'b0;
      rw(1'b1, `OFS_OCCFG, 32'h0);
      done("profile");
      go();
      load_level <= 2'h3;
      step(3);
      chk(32'({channel_on, fault_status_n, retry_request}), 32'h1);
      rw(1'b0, `OFS_FAULT, 32'h0);
      chk(rd, 32'h1);
      recover();
      rw(1'b0, `OFS_FAULT, 32'h0);
      chk(32'({rd[1:0], fault_status_n}), 32'h1);
      done("threshold");
      for (int s = 0; s < 2; s++)
      begin
         t = 3 + $urandom % 4;
         rw(1'b1, `OFS_TC_OCH1, 32'(t));
         rw(1'b1, `OFS_TC_OCH2, 32'(t + 2));
         rw(1'b1, `OFS_OCCFG, 32'(s << `BIT_W1SEL));
         load_level <= 2'h2;
         go();
         step(1);
         chk(32'(strobe), 32'h1);
         wait_ch(1'b0);
         p = (t + 2 * s) * DIV;
         chk(32'(cyc >= p - 4 && cyc <= p + 3), 32'h1);
         recover();
      end
      rw(1'b1, `OFS_OCCFG, 32'h0);
      rw(1'b1, `OFS_TC_OCH1, 32'h3);
      rw(1'b1, `OFS_TC_OCM1, 32'h3);
      go();
      step(1);
      chk(32'(strobe), 32'h1);
      step(20);
      chk(32'({strobe, channel_on}), 32'h1);
      on_cmd <= 1'b0;
      step(2);
      go();
      step(1);
      chk(32'(strobe), 32'h1);
      switch_mode <= 1'b1;
      step(20);
      on_cmd <= 1'b0;
      step(2);
      go();
      step(1);
      chk(32'(strobe), 32'h0);
      recover();
      done("lighting");
      profile_pin <= 1'b1;
      rw(1'b1, `OFS_TC_OCM1, 32'h8);
      go();
      step(3);
      chk(32'(strobe), 32'h0);
      load_level <= 2'h1;
      step(2);
      chk(32'(strobe), 32'h1);
      wait_ch(1'b0);
      // trip once the count passes 8 ticks, i.e. at the ninth tick after the window opens
      chk(32'(cyc >= 9 * DIV && cyc <= 9 * DIV + 2), 32'h1);
      recover();
      switch_mode <= 1'b1;
      load_level <= 2'h1;
      p = 0;
      while (fault_status_n !== 1'b0 && p < 12)
      begin
         on_cmd <= 1'b1;
         step(5);
         on_cmd <= 1'b0;
         step(5);
         p++;
      end
      chk(32'(p >= 3 && p <= 6), 32'h1);
      recover();
      go();
      load_level <= 2'h1;
      step(8);
      on_cmd <= 1'b0;
      load_level <= 2'h0;
      step(2);
      go();
      step(4);
      on_cmd <= 1'b0;
      step(2);
      go();
      load_level <= 2'h1;
      wait_ch(1'b0);
      // without the clean-period reset the four ticks of the first period would trip it early
      chk(32'(cyc >= 9 * DIV && cyc <= 9 * DIV + 4), 32'h1);
      recover();
      profile_pin <= 1'b0;
      done("motor");
      retry_enable <= 1'b1;
      rw(1'b1, `OFS_TC_OCH1, 32'h3);
      load_level <= 2'h2;
      go();
      wait_ch(1'b0);
      step(2);
      chk(32'(retry_request), 32'h1);
      retry_turn_on <= 1'b1;
      @(posedge clk);
      retry_turn_on <= 1'b0;
      wait_ch(1'b1);
      chk(32'(channel_on), 32'h1);
      wait_ch(1'b0);
      chk(32'(cyc >= 2 && cyc <= 9), 32'h1);
      // the last allowed retry still turns on; its fault latches and later retries are refused
      retry_exhausted <= 1'b1;
      retry_turn_on <= 1'b1;
      @(posedge clk);
      retry_turn_on <= 1'b0;
      wait_ch(1'b1);
      wait_ch(1'b0);
      chk(32'(channel_on), 32'h0);
      retry_turn_on <= 1'b1;
      @(posedge clk);
      retry_turn_on <= 1'b0;
      step(6);
      chk(32'(channel_on), 32'h0);
      retry_exhausted <= 1'b0;
      recover();
      done("retry");
      short_cmd <= 1'b1;
      on_cmd <= 1'b1;
      step(6);
      chk(32'({channel_on, fault_status_n}), 32'h0);
      rw(1'b0, `OFS_FAULT, 32'h0);
      chk(32'(rd[`BIT_SC]), 32'h1);
      supply_por <= 1'b1;
      step(2);
      supply_por <= 1'b0;
      short_cmd <= 1'b0;
      on_cmd <= 1'b0;
      rw(1'b0, `OFS_FAULT, 32'h0);
      rw(1'b0, `OFS_FAULT, 32'h0);
      chk(32'({rd[1:0], fault_status_n}), 32'h1);
      recover();
      done("short");
      go();
      supply_state <= 2'h2;
      step(3);
      chk(32'({channel_on, fault_status_n}), 32'h0);
      supply_state <= 2'h3;
      step(3);
      rw(1'b0, `OFS_STATUS, 32'h0);
      rw(1'b0, `OFS_STATUS, 32'h0);
      chk(32'({channel_on, rd[`BIT_OV]}), 32'h1);
      supply_state <= 2'h0;
      rw(1'b0, `OFS_STATUS, 32'h0);
      rw(1'b0, `OFS_STATUS, 32'h0);
      chk(32'(rd[`BIT_OV]), 32'h0);
      recover();
      rw(1'b1, `OFS_GCFG, 32'h1);
      go();
      supply_state <= 2'h2;
      step(3);
      rw(1'b0, `OFS_STATUS, 32'h0);
      chk(32'({channel_on, fault_status_n, rd[`BIT_OV]}), 32'h7);
      rw(1'b1, `OFS_GCFG, 32'h0);
      recover();
      done("overvoltage");
      go();
      supply_state <= 2'h1;
      step(3);
      rw(1'b0, `OFS_STATUS, 32'h0);
      chk(32'({channel_on, fault_status_n, rd[`BIT_UV]}), 32'h1);
      supply_state <= 2'h0;
      step(4);
      chk(32'(channel_on), 32'h0);
      pulse_delatch();
      wait_ch(1'b1);
      chk(32'(channel_on), 32'h1);
      on_cmd <= 1'b0;
      supply_state <= 2'h1;
      step(3);
      supply_state <= 2'h0;
      step(3);
      rw(1'b0, `OFS_STATUS, 32'h0);
      chk(32'({fault_status_n, rd[`BIT_UV]}), 32'h3);
      // the read above cleared the last flag, so only the overheat input can raise the request
      step(2);
      chk(32'(retry_request), 32'h0);
      overheat_flag <= 1'b1;
      step(3);
      chk(32'(retry_request), 32'h1);
      overheat_flag <= 1'b0;
      recover();
      done("undervoltage");
      close_out();
   end
endmodule
